// ### design/lsa_cfg.svh
// offsets, field positions, opcodes and reset values of the logic/sign/abs datapath
`ifndef LSA_CFG_SVH
`define LSA_CFG_SVH

// apb register byte offsets
`define LSA_OFF_CTRL     8'h00
`define LSA_OFF_SRC      8'h04
`define LSA_OFF_SRC2     8'h08
`define LSA_OFF_FPA_HI   8'h0C
`define LSA_OFF_FPA_LO   8'h10
`define LSA_OFF_FPB_HI   8'h14
`define LSA_OFF_FPB_LO   8'h18
`define LSA_OFF_INSTR    8'h1C
`define LSA_OFF_GRES     8'h20
`define LSA_OFF_FRES_HI  8'h24
`define LSA_OFF_FRES_LO  8'h28
`define LSA_OFF_STATUS   8'h2C

// control register fields
`define LSA_CTRL_RN_LSB  0
`define LSA_CTRL_SO_BIT  4
`define LSA_CTRL_FS_LSB  8

// status register fields
`define LSA_ST_CR0_LSB   0
`define LSA_ST_CR1_LSB   4
`define LSA_ST_GWR_BIT   8
`define LSA_ST_FWR_BIT   9
`define LSA_ST_ILL_BIT   10

// instruction encodings
`define LSA_OP_FIXED     6'h1F
`define LSA_OP_FLOAT_D   6'h3F
`define LSA_OP_FLOAT_S   6'h3B
`define LSA_XO_EQUIV     10'h11C
`define LSA_XO_EXT_BYTE  10'h3BA
`define LSA_XO_EXT_HALF  9'h19A
`define LSA_XO_FP_ABS    10'h108
`define LSA_XO_FP_ADD    5'h15

// reset values
`define LSA_RST_WORD     32'h0000_0000
`define LSA_RST_DWORD    64'h0000_0000_0000_0000

`endif

// ### design/lsa_pkg.sv
// types shared by the logic/sign/abs datapath
package lsa_pkg;

    // kind of operation decoded from the instruction word
    typedef enum logic [2:0] {
        LSA_NONE,
        LSA_EQUIV,
        LSA_EXTB,
        LSA_EXTH,
        LSA_FABS,
        LSA_FADD_D,
        LSA_FADD_S
    } lsa_op_type;

    // whole state of the datapath block
    typedef struct packed {
        logic [1:0]  roundMode;   // rounding-control field
        logic        sumOvf;      // fixed-point summary overflow
        logic [3:0]  fpSummary;   // exception, enabled, invalid, overflow
        logic [31:0] srcA;        // source_gpr value
        logic [31:0] srcB;        // second_source_gpr value
        logic [63:0] fpA;         // fp_first_reg value
        logic [63:0] fpB;         // fp_source_reg value
        logic [31:0] instr;       // last issued instruction
        logic [31:0] gprRes;      // dest_gpr value
        logic [63:0] fprRes;      // fp_target_reg value
        logic [3:0]  cr0;         // condition field 0
        logic [3:0]  cr1;         // condition field 1
        logic        gprWr;       // last op wrote dest_gpr
        logic        fprWr;       // last op wrote fp_target_reg
        logic        illegal;     // last op was not decoded
        logic        pready;      // apb answer
        logic        pslverr;     // apb error answer
        logic [31:0] prdata;      // apb read data
    } lsa_state_type;

endpackage : lsa_pkg

// ### design/lsa_datapath.sv
// logic, sign-extension and fp abs/add datapath with apb access
`timescale 1ns/1ps
`include "lsa_cfg.svh"
module lsa_datapath
    import lsa_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    // condition field 0 from a 32-bit result
    function automatic logic [3:0] cr0Of(input logic [31:0] res, input logic so);
        cr0Of = {res[31], !res[31] && (res != 32'h0000_0000), res == 32'h0000_0000, so};
    endfunction : cr0Of

    // decode the instruction word into an operation kind
    function automatic lsa_op_type decodeOp(input logic [31:0] iw);
        decodeOp = LSA_NONE;
        if (iw[5:1] == `LSA_XO_FP_ADD && iw[31:26] == `LSA_OP_FLOAT_D)
            decodeOp = LSA_FADD_D;
        else if (iw[5:1] == `LSA_XO_FP_ADD && iw[31:26] == `LSA_OP_FLOAT_S)
            decodeOp = LSA_FADD_S;
        else if (iw[31:26] == `LSA_OP_FLOAT_D && iw[10:1] == `LSA_XO_FP_ABS)
            decodeOp = LSA_FABS;
        else if (iw[31:26] == `LSA_OP_FIXED && iw[10:1] == `LSA_XO_EQUIV)
            decodeOp = LSA_EQUIV;
        else if (iw[31:26] == `LSA_OP_FIXED && iw[10:1] == `LSA_XO_EXT_BYTE)
            decodeOp = LSA_EXTB;
        // halfword form ignores the overflow-enable bit 21
        else if (iw[31:26] == `LSA_OP_FIXED && iw[9:1] == `LSA_XO_EXT_HALF)
            decodeOp = LSA_EXTH;
    endfunction : decodeOp

    // normal-number fp add; denormals keep their fraction with no hidden bit, overflow not saturated
    function automatic logic [63:0] fpAdd(input logic [63:0] a, input logic [63:0] b,
                                          input logic [1:0] rn, input logic single);
        logic [63:0] x;
        logic [63:0] y;
        logic [10:0] ex;
        logic [10:0] ey;
        logic [56:0] mx;
        logic [56:0] my;
        logic [56:0] sum;
        logic [56:0] rmask;
        logic [56:0] half;
        logic [56:0] lsbv;
        logic        sticky;
        logic        up;
        x = a;
        y = b;
        if (a[62:0] < b[62:0])
        begin
            x = b;
            y = a;
        end
        ex = x[62:52];
        ey = y[62:52];
        mx = {1'b0, ex != 11'h000, x[51:0], 3'h0};
        my = {1'b0, ey != 11'h000, y[51:0], 3'h0};
        sticky = 1'b0;
        // align the smaller operand, folding lost bits into sticky
        for (int i = 0; i < 57; i++)
        begin
            if (11'(i) < ex - ey)
            begin
                sticky = sticky | my[0];
                my = my >> 1;
            end
        end
        my[0] = my[0] | sticky;
        sum = (x[63] == y[63]) ? mx + my : mx - my;
        if (sum == 57'h0)
        begin
            fpAdd = {rn == 2'h3, 63'h0};
        end
        else
        begin
            if (sum[56])
            begin
                sum = {1'b0, sum[56:2], sum[1] | sum[0]};
                ex = ex + 11'h001;
            end
            // normalise so the hidden bit sits at bit 55
            for (int i = 0; i < 56; i++)
            begin
                if (!sum[55])
                begin
                    sum = sum << 1;
                    ex = ex - 11'h001;
                end
            end
            lsbv = single ? 57'h1 << 32 : 57'h1 << 3;
            rmask = lsbv - 57'h1;
            half = lsbv >> 1;
            // round increment chosen by rounding control
            case (rn)
                2'h0:    up = ((sum & rmask) > half) ||
                              ((sum & rmask) == half && (sum & lsbv) != 57'h0);
                2'h1:    up = 1'b0;
                2'h2:    up = !x[63] && (sum & rmask) != 57'h0;
                default: up = x[63] && (sum & rmask) != 57'h0;
            endcase
            sum = (sum & ~rmask) + (up ? lsbv : 57'h0);
            if (sum[56])
            begin
                sum = sum >> 1;
                ex = ex + 11'h001;
            end
            fpAdd = {x[63], ex, sum[54:3]};
        end
    endfunction : fpAdd

    ////////////////////////////////////////////////////////////////////////
    // state

    lsa_state_type st;           // registered state
    lsa_state_type next_st;      // next state
    logic          access;       // apb access phase not yet answered
    logic          wrExec;       // write to the instruction register
    lsa_op_type    opKind;       // decoded operation of pwdata
    logic          rec;          // record flag of pwdata

    assign access = psel && penable && !st.pready;
    assign wrExec = access && pwrite && paddr == `LSA_OFF_INSTR;
    assign opKind = decodeOp(pwdata);
    assign rec    = pwdata[0];

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: apb decode and execution

    always_comb
    begin
        next_st = st;
        next_st.pready  = access;
        next_st.pslverr = 1'b0;
        next_st.prdata  = `LSA_RST_WORD;
        // one wait state, then answer; unmapped offsets raise pslverr
        if (access)
        begin
            case (paddr)
                `LSA_OFF_CTRL:
                begin
                    next_st.prdata = {20'h0, st.fpSummary, 3'h0, st.sumOvf, 2'h0, st.roundMode};
                    if (pwrite)
                    begin
                        next_st.roundMode = pwdata[`LSA_CTRL_RN_LSB +: 2];
                        next_st.sumOvf    = pwdata[`LSA_CTRL_SO_BIT];
                        next_st.fpSummary = pwdata[`LSA_CTRL_FS_LSB +: 4];
                    end
                end
                `LSA_OFF_SRC:     begin next_st.prdata = st.srcA;  if (pwrite) next_st.srcA = pwdata; end
                `LSA_OFF_SRC2:    begin next_st.prdata = st.srcB;  if (pwrite) next_st.srcB = pwdata; end
                `LSA_OFF_FPA_HI:  begin next_st.prdata = st.fpA[63:32]; if (pwrite) next_st.fpA[63:32] = pwdata; end
                `LSA_OFF_FPA_LO:  begin next_st.prdata = st.fpA[31:0];  if (pwrite) next_st.fpA[31:0] = pwdata; end
                `LSA_OFF_FPB_HI:  begin next_st.prdata = st.fpB[63:32]; if (pwrite) next_st.fpB[63:32] = pwdata; end
                `LSA_OFF_FPB_LO:  begin next_st.prdata = st.fpB[31:0];  if (pwrite) next_st.fpB[31:0] = pwdata; end
                `LSA_OFF_INSTR:   next_st.prdata = st.instr;
                `LSA_OFF_GRES:    next_st.prdata = st.gprRes;
                `LSA_OFF_FRES_HI: next_st.prdata = st.fprRes[63:32];
                `LSA_OFF_FRES_LO: next_st.prdata = st.fprRes[31:0];
                `LSA_OFF_STATUS:
                    next_st.prdata = {21'h0, st.illegal, st.fprWr, st.gprWr, st.cr1, st.cr0};
                default:          next_st.pslverr = 1'b1;
            endcase
        end
        // execute on the write to the instruction register
        if (wrExec)
        begin
            next_st.instr   = pwdata;
            next_st.gprWr   = 1'b0;
            next_st.fprWr   = 1'b0;
            next_st.illegal = 1'b0;
            case (opKind)
                LSA_EQUIV:
                begin
                    next_st.gprRes = ~(st.srcA ^ st.srcB);
                    next_st.gprWr  = 1'b1;
                end
                LSA_EXTB:
                begin
                    next_st.gprRes = {{24{st.srcA[7]}}, st.srcA[7:0]};
                    next_st.gprWr  = 1'b1;
                end
                LSA_EXTH:
                begin
                    next_st.gprRes = {{16{st.srcA[15]}}, st.srcA[15:0]};
                    next_st.gprWr  = 1'b1;
                end
                LSA_FABS:
                begin
                    next_st.fprRes = {1'b0, st.fpB[62:0]};
                    next_st.fprWr  = 1'b1;
                end
                LSA_FADD_D, LSA_FADD_S:
                begin
                    // add and round into the target
                    next_st.fprRes = fpAdd(st.fpA, st.fpB, st.roundMode, opKind == LSA_FADD_S);
                    next_st.fprWr  = 1'b1;
                end
                default: next_st.illegal = 1'b1;
            endcase
            // record form updates field 0, sumOvf never written
            if (rec && (opKind == LSA_EQUIV || opKind == LSA_EXTB || opKind == LSA_EXTH))
                next_st.cr0 = cr0Of(next_st.gprRes, st.sumOvf);
            // record form copies summary bits, status untouched
            if (rec && (opKind == LSA_FABS || opKind == LSA_FADD_D || opKind == LSA_FADD_S))
                next_st.cr1 = st.fpSummary;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign pready  = st.pready;
    assign prdata  = st.prdata;
    assign pslverr = st.pslverr;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    equiv_result_a: assert property (wrExec && opKind == LSA_EQUIV |=>
        st.gprRes == ~($past(st.srcA) ^ $past(st.srcB)) && st.gprWr)
        else $error("equiv result wrong");
    equiv_keeps_a: assert property (wrExec && opKind == LSA_EQUIV && !rec |=>
        $stable(st.cr0) && $stable(st.sumOvf))
        else $error("equiv touched field 0");
    byte_ext_a: assert property (wrExec && opKind == LSA_EXTB |=>
        st.gprRes == {{24{$past(st.srcA[7])}}, $past(st.srcA[7:0])})
        else $error("byte extension wrong");
    byte_rec_a: assert property (wrExec && opKind == LSA_EXTB && rec |=>
        st.cr0[1] == (st.gprRes == 32'h0000_0000) && st.cr0[3] == st.gprRes[31])
        else $error("byte record field 0 wrong");
    half_ext_a: assert property (wrExec && opKind == LSA_EXTH |=>
        st.gprRes == {{16{$past(st.srcA[15])}}, $past(st.srcA[15:0])})
        else $error("halfword extension wrong");
    half_rec_a: assert property (wrExec && opKind == LSA_EXTH && rec |=>
        st.cr0[0] == st.sumOvf && $stable(st.sumOvf))
        else $error("halfword record wrong");
    abs_result_a: assert property (wrExec && opKind == LSA_FABS |=>
        st.fprRes == {1'b0, $past(st.fpB[62:0])})
        else $error("abs result wrong");
    abs_status_a: assert property (wrExec && opKind == LSA_FABS && rec |=>
        st.cr1 == st.fpSummary && $stable(st.fpSummary) && $stable(st.roundMode))
        else $error("abs status or field 1 wrong");
    add_decode_a: assert property (wrExec && pwdata[31:26] == `LSA_OP_FLOAT_S &&
        pwdata[5:1] == `LSA_XO_FP_ADD |=> st.fprWr && !st.illegal)
        else $error("single add not decoded");
    add_trunc_a: assert property (wrExec && opKind == LSA_FADD_S |=>
        st.fprRes[28:0] == 29'h0)
        else $error("single add not rounded to single");
    field0_sign_a: assert property (wrExec && rec && opKind == LSA_EQUIV |=>
        st.cr0[3:2] == {st.gprRes[31], !st.gprRes[31] && st.gprRes != 32'h0000_0000})
        else $error("field 0 compare wrong");
    apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    equiv_rec_c: cover property (wrExec && opKind == LSA_EQUIV && rec);
    fadd_d_c:    cover property (wrExec && opKind == LSA_FADD_D);
    unmapped_c:  cover property (pready && pslverr);

endmodule : lsa_datapath

// ### sim/lsa_testbench.sv
// self-checking random testbench for the logic/sign/abs datapath
`timescale 1ns/1ps
`include "lsa_cfg.svh"
module testbench;

////////////////////////////////////////////////////////////////////////////////
logic        clk_sys;          // 50 MHz core clock
logic        rst_n;            // async reset, active low
logic        psel;             // apb select
logic        penable;          // apb access phase
logic        pwrite;           // apb direction
logic [7:0]  paddr;            // apb byte address
logic [31:0] pwdata;           // apb write data
logic        pready;           // apb answer
logic [31:0] prdata;           // apb read data
logic        pslverr;          // apb error answer
int          error_cnt;        // mismatches seen
int          samples_checked;  // comparisons made
integer      seed;             // fixed seed keeps runs repeatable
logic [3:0]  eCr0;             // expected condition field 0
logic [3:0]  eCr1;             // expected condition field 1
logic [2:0]  eFlg;             // expected {illegal, fpr written, gpr written}
logic [31:0] eG;               // expected gpr result
logic [31:0] rv;               // scratch read value
logic        re;               // scratch error flag

lsa_datapath dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

// free-running clock, 20 ns period
always #10 clk_sys = ~clk_sys;

////////////////////////////////////////////////////////////////////////////////
// compare and count; unknowns never match
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
        error_cnt++;
        $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
endtask : check

// one apb transfer; no cycle count assumed, bounded wait for pready
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                   output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
        @(posedge clk_sys);
        n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
        error_cnt++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask : apb

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, re);
endtask : wr

task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rv, re);
    check(rv, exp);
endtask : rdchk

// instruction word with random register fields, which the block ignores
function automatic logic [31:0] mk(input logic [5:0] op, input logic [9:0] xo, input logic rc);
    logic [14:0] fld;
    fld = 15'($random(seed));
    return {op, fld, xo, rc};
endfunction : mk

// field 0 from a signed compare of the result with zero
function automatic logic [3:0] cr0f(input logic [31:0] v, input logic so);
    return {v[31], !v[31] && (v != 32'h0000_0000), v == 32'h0000_0000, so};
endfunction : cr0f

function automatic logic [31:0] stat();
    return {21'h000000, eFlg, eCr1, eCr0};
endfunction : stat

// verdict and end of run
task tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask : tally_and_finish

////////////////////////////////////////////////////////////////////////////////
// watchdog: far beyond the few thousand cycles the sequence needs
initial
begin
    #600000;
    error_cnt++;
    tally_and_finish();
end

// main sequence
initial
begin
    logic [31:0] a, b, ctl, g, ins;
    logic [9:0]  xo;
    logic [63:0] fa, fb, fr;
    logic        rc;
    logic [63:0] addA [3];    // add operands a, exact in single too
    logic [63:0] addB [3];    // add operands b
    logic [63:0] addR [3];    // expected sums
    logic [31:0] corner [4];  // sign-bit corner sources
    addA = '{64'h3FF0_0000_0000_0000, 64'hC053_4000_0000_0000, 64'h0};
    addB = '{64'h4000_0000_0000_0000, 64'h400C_0000_0000_0000, 64'h0};
    addR = '{64'h4008_0000_0000_0000, 64'hC052_6000_0000_0000, 64'h0};
    corner = '{32'h0000_0080, 32'h0000_8000, 32'h7FFF_7F7F, 32'h0000_0000};
    clk_sys = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; error_cnt = 0; samples_checked = 0;
    seed = 32'h5B92; eCr0 = 4'h0; eCr1 = 4'h0; eFlg = 3'h0; eG = 32'h0000_0000;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(`LSA_OFF_CTRL, 32'h0000_0000);
    rdchk(`LSA_OFF_STATUS, 32'h0000_0000);
    // unmapped offset answers with an error and zero data
    rdchk(8'h30, 32'h0000_0000);
    check({31'h0, re}, 32'h0000_0001);
    for (int i = 0; i < 24; i++)
    begin
        a = (i < 4) ? corner[i] : 32'($random(seed));
        b = 32'($random(seed));
        ctl = 32'($random(seed)) & 32'h0000_0F13;
        wr(`LSA_OFF_CTRL, ctl);
        wr(`LSA_OFF_SRC, a);
        wr(`LSA_OFF_SRC2, b);
        // complement-xor, byte and halfword extension, halfword with and without bit 21
        for (int k = 0; k < 4; k++)
        begin
            rc = 1'($random(seed));
            xo = (k == 0) ? `LSA_XO_EQUIV : (k == 1) ? `LSA_XO_EXT_BYTE : (k == 2) ? 10'h39A : 10'h19A;
            g = (k == 0) ? ~(a ^ b) : (k == 1) ? {{24{a[7]}}, a[7:0]} : {{16{a[15]}}, a[15:0]};
            wr(`LSA_OFF_INSTR, mk(`LSA_OP_FIXED, xo, rc));
            eG = g;
            eFlg = 3'b001;
            if (rc)
                eCr0 = cr0f(g, ctl[4]);
            rdchk(`LSA_OFF_GRES, eG);
            rdchk(`LSA_OFF_STATUS, stat());
        end
        rdchk(`LSA_OFF_CTRL, ctl);
    end
    for (int i = 0; i < 12; i++)
    begin
        fa = {32'($random(seed)), 32'($random(seed))};
        fb = {32'($random(seed)), 32'($random(seed))};
        fr = {1'b0, fb[62:0]};
        rc = 1'($random(seed));
        ins = mk(`LSA_OP_FLOAT_D, `LSA_XO_FP_ABS, rc);
        if (i >= 6)
        begin
            fa = addA[i % 2];
            fb = addB[i % 2];
            fr = addR[i % 2];
            xo = {5'($random(seed)), `LSA_XO_FP_ADD};
            ins = mk((i >= 9) ? `LSA_OP_FLOAT_S : `LSA_OP_FLOAT_D, xo, rc);
        end
        ctl = 32'($random(seed)) & 32'h0000_0F13;
        wr(`LSA_OFF_CTRL, ctl);
        wr(`LSA_OFF_FPA_HI, fa[63:32]);
        wr(`LSA_OFF_FPA_LO, fa[31:0]);
        wr(`LSA_OFF_FPB_LO, fb[31:0]);
        wr(`LSA_OFF_FPB_HI, fb[63:32]);
        wr(`LSA_OFF_INSTR, ins);
        eFlg = 3'b010;
        if (rc)
            eCr1 = ctl[11:8];
        rdchk(`LSA_OFF_FRES_HI, fr[63:32]);
        rdchk(`LSA_OFF_FRES_LO, fr[31:0]);
        rdchk(`LSA_OFF_STATUS, stat());
        rdchk(`LSA_OFF_CTRL, ctl);
    end
    // undecoded word: flagged, field 0 left alone despite the record bit
    wr(`LSA_OFF_INSTR, mk(`LSA_OP_FIXED, 10'h000, 1'b1));
    apb(1'b0, `LSA_OFF_STATUS, 32'h0000_0000, rv, re);
    check(rv & 32'h0000_040F, {21'h000000, 3'b100, 4'h0, eCr0});
    // result register is read-only
    wr(`LSA_OFF_GRES, ~eG);
    rdchk(`LSA_OFF_GRES, eG);
    tally_and_finish();
end

endmodule : testbench
